// *** src/bbid_datapath.sv ***
// byte and bit instruction datapath with an axi4-lite register slave
`timescale 1ns/10ps
`include "bbid_defines.svh"

module bbid_datapath import bbid_pkg::*; (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // first io port
   input wire logic [7:0] port_pins,
   output logic [7:0] port_latch,
   // timer side effects and status
   output logic prescaler_clear,
   output logic instr_busy
);

   // ****************************************
   // state
   // ****************************************
   logic aw_held; // write address waiting
   logic [11:0] aw_addr; // captured write address
   logic w_held; // write data waiting
   logic [31:0] w_data; // captured write data
   logic [3:0] w_strb; // captured byte enables
   logic [1:0] bresp; // write answer code
   logic bvalid; // write answer pending
   logic [31:0] rdata; // read answer data
   logic [1:0] rresp; // read answer code
   logic rvalid; // read answer pending
   bbid_state_t state; // execution state
   bbid_instr_t instr; // instruction under way
   logic [7:0] acc; // accumulator
   bbid_flags_t flags; // carry, nibble carry, zero
   logic skip_pending; // next instruction is dropped
   logic psa; // prescaler belongs to the timer
   logic [7:0] presc; // prescaler count
   logic presc_clr; // one-cycle prescaler clear
   logic [7:0] latch; // port output latch
   logic [7:0] file_mem [0:127]; // file registers

   // ****************************************
   // next values
   // ****************************************
   logic next_aw_held;
   logic [11:0] next_aw_addr;
   logic next_w_held;
   logic [31:0] next_w_data;
   logic [3:0] next_w_strb;
   logic [1:0] next_bresp;
   logic next_bvalid;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;
   logic next_rvalid;
   bbid_state_t next_state;
   bbid_instr_t next_instr;
   logic [7:0] next_acc;
   bbid_flags_t next_flags;
   logic next_skip_pending;
   logic next_psa;
   logic [7:0] next_presc;
   logic next_presc_clr;
   logic [7:0] next_latch;

   // ****************************************
   // combinational helpers
   // ****************************************
   logic commit; // address and data both held, no write answer pending
   logic mem_we; // file write strobe
   logic [6:0] mem_idx; // file write index
   logic [7:0] mem_wd; // file write data
   logic [7:0] operand; // file operand of the instruction
   logic tested; // selected bit of the operand
   logic [8:0] sum; // nine-bit sum
   logic [4:0] nib_sum; // low nibble sum
   logic [7:0] bit_mask; // one-hot selected bit
   logic [6:0] rd_idx; // file index of a read

   // handshake outputs straight from the hold flags
   assign s_axi_awready = ~aw_held;
   assign s_axi_wready = ~w_held;
   assign s_axi_bvalid = bvalid;
   assign s_axi_bresp = bresp;
   assign s_axi_arready = ~rvalid;
   assign s_axi_rvalid = rvalid;
   assign s_axi_rdata = rdata;
   assign s_axi_rresp = rresp;
   assign port_latch = latch;
   assign prescaler_clear = presc_clr;
   assign instr_busy = (state != st_idle);
   assign commit = aw_held & w_held & ~bvalid;
   assign rd_idx = s_axi_araddr[8:2];

   // operand fetch: the port reads its pins, never its latch
   always_comb begin
      if (instr.faddr == `BBID_PORT_IDX) begin
         operand = port_pins;
      end else begin
         operand = file_mem[instr.faddr];
      end
      tested = operand[instr.bit_sel];
      bit_mask = 8'h01 << instr.bit_sel;
   end

   // adder with carry out of bits 3 and 7
   always_comb begin
      if (bbid_op_t'(instr.op) == add_immediate_op) begin
         sum = {1'b0, acc} + {1'b0, instr.literal};
         nib_sum = {1'b0, acc[3:0]} + {1'b0, instr.literal[3:0]};
      end else begin
         sum = {1'b0, acc} + {1'b0, operand};
         nib_sum = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};
      end
   end

   // ****************************************
   // axi write and read channels
   // ****************************************

   // capture address and data in either order, answer after both
   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held = w_held;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = bvalid;
      next_bresp = bresp;
      if (s_axi_awvalid && !aw_held) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (commit) begin
         // both parts used: release them and answer
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = `BBID_RESP_OKAY;
         if (aw_addr == `BBID_INSTR_OFS && state != st_idle) begin
            next_bresp = `BBID_RESP_SLVERR; // refused while busy
         end else if (aw_addr == `BBID_CTRL_OFS || aw_addr == `BBID_INSTR_OFS) begin
            next_bresp = `BBID_RESP_OKAY;
         end else if (aw_addr == `BBID_ACC_OFS || aw_addr == `BBID_STATUS_OFS) begin
            next_bresp = `BBID_RESP_OKAY;
         end else if (aw_addr == `BBID_LATCH_OFS || aw_addr[11:9] == `BBID_FILE_REGION) begin
            next_bresp = `BBID_RESP_OKAY;
         end else begin
            next_bresp = `BBID_RESP_SLVERR; // unmapped or read only
         end
      end
   end

   // read decode, answered one cycle after the address is taken
   always_comb begin
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      if (rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && !rvalid) begin
         next_rvalid = 1'b1;
         next_rresp = `BBID_RESP_OKAY;
         next_rdata = 32'h0000_0000;
         if (s_axi_araddr == `BBID_CTRL_OFS) begin
            next_rdata[`BBID_CTRL_PSA_BIT] = psa;
         end else if (s_axi_araddr == `BBID_INSTR_OFS) begin
            next_rdata = instr;
         end else if (s_axi_araddr == `BBID_ACC_OFS) begin
            next_rdata[7:0] = acc;
         end else if (s_axi_araddr == `BBID_STATUS_OFS) begin
            next_rdata[`BBID_ST_C_BIT] = flags.c;
            next_rdata[`BBID_ST_NIBBLE_BIT] = flags.nibble_carry;
            next_rdata[`BBID_ST_Z_BIT] = flags.z;
            next_rdata[`BBID_ST_BUSY_BIT] = (state != st_idle);
            next_rdata[`BBID_ST_SKIP_BIT] = skip_pending;
         end else if (s_axi_araddr == `BBID_PRESC_OFS) begin
            next_rdata[7:0] = presc;
         end else if (s_axi_araddr == `BBID_LATCH_OFS) begin
            next_rdata[7:0] = latch;
         end else if (s_axi_araddr[11:9] == `BBID_FILE_REGION) begin
            if (rd_idx == `BBID_PORT_IDX) begin
               next_rdata[7:0] = port_pins; // port reads its pins
            end else begin
               next_rdata[7:0] = file_mem[rd_idx];
            end
         end else begin
            next_rresp = `BBID_RESP_SLVERR; // unmapped
         end
      end
   end

   // ****************************************
   // instruction execution
   // ****************************************

   // bus writes first, the executing instruction overrides
   always_comb begin
      next_state = state;
      next_instr = instr;
      next_acc = acc;
      next_flags = flags;
      next_skip_pending = skip_pending;
      next_psa = psa;
      next_latch = latch;
      next_presc = psa ? presc + 8'h01 : presc;
      next_presc_clr = 1'b0;
      mem_we = 1'b0;
      mem_idx = aw_addr[8:2];
      mem_wd = w_data[7:0];
      // software register writes
      if (commit && w_strb[0]) begin
         if (aw_addr == `BBID_CTRL_OFS) begin
            next_psa = w_data[`BBID_CTRL_PSA_BIT];
         end else if (aw_addr == `BBID_ACC_OFS) begin
            next_acc = w_data[7:0];
         end else if (aw_addr == `BBID_STATUS_OFS) begin
            next_flags.c = w_data[`BBID_ST_C_BIT];
            next_flags.nibble_carry = w_data[`BBID_ST_NIBBLE_BIT];
            next_flags.z = w_data[`BBID_ST_Z_BIT];
         end else if (aw_addr == `BBID_LATCH_OFS) begin
            next_latch = w_data[7:0];
         end else if (aw_addr[11:9] == `BBID_FILE_REGION) begin
            if (aw_addr[8:2] == `BBID_PORT_IDX) begin
               next_latch = w_data[7:0];
            end else begin
               mem_we = 1'b1;
            end
         end
      end
      case (state)
         st_idle: begin
            // a new instruction, dropped if a skip was taken
            if (commit && aw_addr == `BBID_INSTR_OFS) begin
               next_instr = w_data;
               if (skip_pending) begin
                  next_skip_pending = 1'b0;
                  next_state = st_nop;
               end else begin
                  next_state = st_exec;
               end
            end
         end
         st_exec: begin
            next_state = st_idle;
            mem_idx = instr.faddr;
            case (bbid_op_t'(instr.op))
               add_immediate_op: begin
                  next_acc = sum[7:0];
                  next_flags.c = sum[8];
                  next_flags.nibble_carry = nib_sum[4];
                  next_flags.z = (sum[7:0] == 8'h00);
               end
               add_register_op: begin
                  next_flags.c = sum[8];
                  next_flags.nibble_carry = nib_sum[4];
                  next_flags.z = (sum[7:0] == 8'h00);
                  mem_wd = sum[7:0];
                  if (!instr.dest) begin
                     next_acc = sum[7:0];
                  end else begin
                     mem_we = 1'b1;
                  end
               end
               and_immediate_op: begin
                  next_acc = acc & instr.literal;
                  next_flags.z = ((acc & instr.literal) == 8'h00);
               end
               and_register_op: begin
                  mem_wd = acc & operand;
                  next_flags.z = ((acc & operand) == 8'h00);
                  if (!instr.dest) begin
                     next_acc = acc & operand;
                  end else begin
                     mem_we = 1'b1;
                  end
               end
               bit_clear_op: begin
                  mem_wd = operand & ~bit_mask;
                  mem_we = 1'b1;
               end
               bit_set_op: begin
                  mem_wd = operand | bit_mask;
                  mem_we = 1'b1;
               end
               test_skip_if_zero_op: begin
                  if (!tested) begin
                     next_skip_pending = 1'b1;
                     next_state = st_nop;
                  end
               end
               test_skip_if_one_op: begin
                  if (tested) begin
                     next_skip_pending = 1'b1;
                     next_state = st_nop;
                  end
               end
               default: begin
                  next_state = st_idle;
               end
            endcase
            // results aimed at the port land in its latch
            if (mem_we && instr.faddr == `BBID_PORT_IDX) begin
               mem_we = 1'b0;
               next_latch = mem_wd;
            end
            // a write to the timer count clears an assigned prescaler
            if (mem_we && instr.faddr == `BBID_TIMER_IDX && psa) begin
               next_presc = `BBID_PRESC_RST;
               next_presc_clr = 1'b1;
            end
         end
         st_nop: begin
            // idle second cycle
            next_state = st_idle;
         end
         default: begin
            next_state = st_idle;
         end
      endcase
   end

   // ****************************************
   // registers
   // ****************************************

   // bus channel registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= 12'h000;
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         bvalid <= 1'b0;
         bresp <= `BBID_RESP_OKAY;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `BBID_RESP_OKAY;
      end else begin
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held <= next_w_held;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end

   // execution registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= st_idle;
         instr <= '0;
         acc <= `BBID_ACC_RST;
         flags <= '0;
         skip_pending <= 1'b0;
         psa <= 1'b0;
         presc <= `BBID_PRESC_RST;
         presc_clr <= 1'b0;
         latch <= `BBID_LATCH_RST;
      end else begin
         state <= next_state;
         instr <= next_instr;
         acc <= next_acc;
         flags <= next_flags;
         skip_pending <= next_skip_pending;
         psa <= next_psa;
         presc <= next_presc;
         presc_clr <= next_presc_clr;
         latch <= next_latch;
      end
   end

   // file register array, no reset as in a real register file
   always_ff @(posedge aclk) begin
      if (mem_we) begin
         file_mem[mem_idx] <= mem_wd;
      end
   end

endmodule

// *** src/bbid_defines.svh ***
// constants for the byte and bit instruction datapath
// Overview of operation
// - read-modify-write of port uses pin levels
// - instruction writing timer count clears assigned prescaler, bus write does not
// - taken skip lasts two cycles, second idle
// - add immediate into accumulator, all three flags
// - bit clear forces chosen bit low, no flags
// - add register to destination, all three flags
// - destination bit 0 accumulator, 1 file register
// - bit set forces chosen bit high, no flags
// - AND immediate into accumulator, zero flag only
// - skip next when tested bit is zero
// - AND register to destination, zero flag only
// - skip next when tested bit is one
`ifndef BBID_DEFINES_SVH
`define BBID_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define BBID_CTRL_OFS 12'h000
`define BBID_INSTR_OFS 12'h004
`define BBID_ACC_OFS 12'h008
`define BBID_STATUS_OFS 12'h00C
`define BBID_PRESC_OFS 12'h010
`define BBID_LATCH_OFS 12'h014
`define BBID_FILE_REGION 3'h1

// ****************************************
// field positions
// ****************************************
`define BBID_CTRL_PSA_BIT 0
`define BBID_ST_C_BIT 0
`define BBID_ST_NIBBLE_BIT 1
`define BBID_ST_Z_BIT 2
`define BBID_ST_BUSY_BIT 8
`define BBID_ST_SKIP_BIT 9

// ****************************************
// special file indices and reset values
// ****************************************
`define BBID_TIMER_IDX 7'h01
`define BBID_PORT_IDX 7'h05
`define BBID_ACC_RST 8'h00
`define BBID_LATCH_RST 8'h00
`define BBID_PRESC_RST 8'h00
`define BBID_RESP_OKAY 2'h0
`define BBID_RESP_SLVERR 2'h2

`endif

// *** src/bbid_pkg.sv ***
// types for the byte and bit instruction datapath
package bbid_pkg;

   // ****************************************
   // operations, in command code order from 0
   // ****************************************
   typedef enum logic [3:0] {
      nop_op,
      add_immediate_op,
      add_register_op,
      and_immediate_op,
      and_register_op,
      bit_clear_op,
      bit_set_op,
      test_skip_if_zero_op,
      test_skip_if_one_op
   } bbid_op_t;

   // ****************************************
   // execution states
   // ****************************************
   typedef enum logic [1:0] {
      st_idle,
      st_exec,
      st_nop
   } bbid_state_t;

   // ****************************************
   // instruction word layout
   // ****************************************
   typedef struct packed {
      logic [7:0] spare;
      logic [7:0] literal;
      logic fill;
      logic [6:0] faddr;
      logic [2:0] bit_sel;
      logic dest;
      logic [3:0] op;
   } bbid_instr_t;

   // ****************************************
   // arithmetic flags
   // ****************************************
   typedef struct packed {
      logic z;
      logic nibble_carry;
      logic c;
   } bbid_flags_t;

endpackage

// *** tb/bbid_datapath_asserts.sv ***
// concurrent checks on the ports of the datapath
`timescale 1ns/10ps
`include "bbid_defines.svh"

module bbid_datapath_asserts (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus answers
   input wire logic s_axi_arready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // port and status
   input wire logic [7:0] port_latch,
   input wire logic prescaler_clear,
   input wire logic instr_busy
);
   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_busy_bound: assert property ($rose(instr_busy) |-> ##[1:2] !instr_busy)
      else $error("busy lasted more than two cycles");
   a_skip_two: assert property (instr_busy [*2] |=> !instr_busy)
      else $error("busy lasted three cycles");
   a_clr_pulse: assert property (prescaler_clear |=> !prescaler_clear)
      else $error("prescaler clear longer than one cycle");
   a_clr_cause: assert property (prescaler_clear |-> $past(instr_busy))
      else $error("prescaler clear without execution");
   a_latch_cause: assert property ($changed(port_latch) |-> $past(instr_busy) || s_axi_bvalid)
      else $error("port latch changed without cause");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address accepted while data pending");
   a_resp_code: assert property (s_axi_bvalid |-> s_axi_bresp inside {`BBID_RESP_OKAY, `BBID_RESP_SLVERR})
      else $error("illegal write response code");
   // main scenarios
   c_skip: cover property (instr_busy [*2]);
   c_clear: cover property (prescaler_clear);
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `BBID_RESP_SLVERR);
endmodule

bind bbid_datapath bbid_datapath_asserts chk_u (.aclk(aclk), .aresetn(aresetn), .s_axi_arready(s_axi_arready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .port_latch(port_latch), .prescaler_clear(prescaler_clear), .instr_busy(instr_busy));

// *** tb/bbid_pins_model.sv ***
// outside device that drives the first io port pins
`timescale 1ns/10ps

module bbid_pins_model (
   // clock
   input wire logic aclk,
   // level asked for by the bench
   input wire logic [7:0] drive_val,
   // levels seen on the pins
   output logic [7:0] port_pins = 8'h00
);
   // pins follow the request one cycle late, like a slow outside driver
   always @(posedge aclk) begin
      port_pins <= drive_val;
   end
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the byte and bit instruction datapath
`timescale 1ns/10ps
`include "bbid_defines.svh"

module tb_top;
   import bbid_pkg::*;
   localparam logic [1:0] OK = `BBID_RESP_OKAY;
   localparam logic [1:0] SE = `BBID_RESP_SLVERR;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, clr, busy;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [7:0] pins, latch;
   logic [7:0] pin_drive = 8'h00;
   int n_fail = 0, checked = 0, busy_n = 0, clr_n = 0;

   // ****************************************
   // clock, monitors, design and pin driver
   // ****************************************
   always #25 aclk = ~aclk;
   // counts busy cycles and prescaler clear pulses
   always @(posedge aclk) begin
      if (busy === 1'b1) busy_n <= busy_n + 1;
      if (clr === 1'b1) clr_n <= clr_n + 1;
   end
   bbid_datapath dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_pins(pins),
      .port_latch(latch), .prescaler_clear(clr), .instr_busy(busy));
   bbid_pins_model pin_u (.aclk(aclk), .drive_val(pin_drive), .port_pins(pins));

   // ****************************************
   // tasks
   // ****************************************
   task end_sim;
      if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask
   function logic [11:0] fa(input logic [6:0] f);
      return 12'h200 | {3'h0, f, 2'h0};
   endfunction
   // one write; both channels offered together, response checked
   task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw, na, nw;
      @(posedge aclk);
      awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1;
      ta = 1'b0; tw = 1'b0;
      while (!(ta && tw)) begin
         @(negedge aclk);
         na = awvalid && awready;
         nw = wvalid && wready;
         @(posedge aclk);
         if (na) begin awvalid <= 1'b0; ta = 1'b1; end
         if (nw) begin wvalid <= 1'b0; tw = 1'b1; end
      end
      do @(negedge aclk); while (bvalid !== 1'b1);
      chk({30'h0, bresp}, {30'h0, er});
      @(posedge aclk); bready <= 1'b1;
      @(posedge aclk); bready <= 1'b0;
   endtask
   // one read, data and response returned
   task rd_raw(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk); araddr <= a; arvalid <= 1'b1;
      do @(negedge aclk); while (arready !== 1'b1);
      @(posedge aclk); arvalid <= 1'b0;
      do @(negedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      @(posedge aclk); rready <= 1'b1;
      @(posedge aclk); rready <= 1'b0;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      rd_raw(a, d, r);
      chk(d, e);
      chk({30'h0, r}, {30'h0, er});
   endtask
   // issue one instruction and poll busy low
   task ex(input bbid_op_t op, input logic dst, input logic [2:0] b, input logic [6:0] f, input logic [7:0] k);
      logic [31:0] d;
      logic [1:0] r;
      busy_n = 0;
      wr(`BBID_INSTR_OFS, {8'h00, k, 1'b0, f, b, dst, op}, OK);
      do rd_raw(`BBID_STATUS_OFS, d, r); while (d[8] !== 1'b0);
   endtask

   // ****************************************
   // tests
   // ****************************************
   initial begin
      logic [31:0] e;
      int c0;
      logic sk;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      // reset values, unmapped read, read-only write
      rd(`BBID_ACC_OFS, 0, OK);
      rd(`BBID_STATUS_OFS, 0, OK);
      rd(`BBID_LATCH_OFS, 0, OK);
      rd(12'h100, 0, SE);
      wr(`BBID_PRESC_OFS, 1, SE);
      // add immediate: nibble carry, then carry out and zero
      wr(`BBID_ACC_OFS, 32'h0F, OK);
      ex(add_immediate_op, 0, 0, 0, 8'h01);
      rd(`BBID_ACC_OFS, 32'h10, OK);
      rd(`BBID_STATUS_OFS, 32'h2, OK);
      ex(add_immediate_op, 0, 0, 0, 8'hF0);
      rd(`BBID_ACC_OFS, 0, OK);
      rd(`BBID_STATUS_OFS, 32'h5, OK);
      // add register to each destination
      wr(fa(16), 32'h88, OK);
      wr(`BBID_ACC_OFS, 32'h88, OK);
      ex(add_register_op, 0, 0, 16, 0);
      rd(`BBID_ACC_OFS, 32'h10, OK);
      rd(fa(16), 32'h88, OK);
      rd(`BBID_STATUS_OFS, 32'h3, OK);
      ex(add_register_op, 1, 0, 16, 0);
      rd(fa(16), 32'h98, OK);
      rd(`BBID_ACC_OFS, 32'h10, OK);
      rd(`BBID_STATUS_OFS, 0, OK);
      // and operations leave carry and nibble carry alone
      wr(`BBID_STATUS_OFS, 32'h3, OK);
      ex(and_immediate_op, 0, 0, 0, 8'h0F);
      rd(`BBID_ACC_OFS, 0, OK);
      rd(`BBID_STATUS_OFS, 32'h7, OK);
      wr(`BBID_ACC_OFS, 32'hF0, OK);
      ex(and_register_op, 1, 0, 16, 0);
      rd(fa(16), 32'h90, OK);
      rd(`BBID_STATUS_OFS, 32'h3, OK);
      // bit set then clear on every bit of the top file index
      wr(fa(127), 0, OK);
      wr(`BBID_STATUS_OFS, 32'h7, OK);
      e = 0;
      for (int i = 0; i < 8; i++) begin
         ex(bit_set_op, 0, i[2:0], 127, 0);
         e[i] = 1'b1;
         rd(fa(127), e, OK);
      end
      rd(`BBID_STATUS_OFS, 32'h7, OK);
      for (int i = 0; i < 8; i++) begin
         ex(bit_clear_op, 0, i[2:0], 127, 0);
         e[i] = 1'b0;
         rd(fa(127), e, OK);
      end
      rd(`BBID_STATUS_OFS, 32'h7, OK);
      // port changes use pin levels, not the latch
      pin_drive <= 8'h3C;
      wr(`BBID_LATCH_OFS, 32'hFF, OK);
      ex(bit_set_op, 0, 0, 5, 0);
      chk({24'h0, latch}, 32'h3D);
      wr(`BBID_ACC_OFS, 32'h02, OK);
      ex(add_register_op, 1, 0, 5, 0);
      rd(`BBID_LATCH_OFS, 32'h3E, OK);
      // timer count writes clear the assigned prescaler
      wr(`BBID_CTRL_OFS, 1, OK);
      wr(fa(1), 0, OK);
      c0 = clr_n;
      ex(bit_set_op, 0, 0, 1, 0);
      ex(and_register_op, 0, 0, 1, 0);
      ex(add_register_op, 1, 0, 1, 0);
      rd(`BBID_PRESC_OFS, 32'h6, OK);
      chk(clr_n - c0, 2);
      // both skip kinds, taken and not taken
      wr(fa(24), 1, OK);
      wr(`BBID_STATUS_OFS, 0, OK);
      for (int i = 0; i < 4; i++) begin
         sk = (i == 0) || (i == 3);
         wr(`BBID_ACC_OFS, 0, OK);
         ex((i < 2) ? test_skip_if_zero_op : test_skip_if_one_op, 0, {2'b00, ~i[0]}, 24, 0);
         chk(busy_n, sk ? 2 : 1);
         rd(`BBID_STATUS_OFS, sk ? 32'h200 : 32'h0, OK);
         ex(add_immediate_op, 0, 0, 0, 8'h01);
         rd(`BBID_ACC_OFS, sk ? 32'h0 : 32'h1, OK);
      end
      end_sim();
   end

   // cuts a hang short
   initial begin
      #(50 * 40000);
      n_fail++;
      end_sim();
   end
endmodule
